// [core/pllcp_pkg.sv]
// ****************************************************************
// Function
// RULE1: PLL locks to 1275 times oscillator.
// RULE2: Core divider picks power-of-two division.
// RULE3: Core divider resets to three.
// RULE4: Core clock can drive the output pin.
// RULE5: Mode and divider come from registers.
// RULE6: Value 0x03 selects external clock input.
// RULE7: Value 0x27 enters nap, slowest divider.
// RULE8: Software arms Timer2 before crystal switch.
// RULE9: Software selects crystal, then forces nap.
// RULE10: Nap wake already runs from new source.
// RULE11: Lock loss halts core, raises interrupt.
// RULE12: Software checks reset cause after watchdog.
// RULE13: External clock accepted when pin mode two.
// RULE14: Each mode gates its own domains.
// RULE15: Wake-up time depends on mode, divider.
// RULE16: Config writes framed by key values.
// RULE17: Power state encoding; sleep wake sources.
// RULE18: Slow oscillator select defaults to internal.
// RULE19: Unframed config writes are ignored.
// ****************************************************************
package pllcp_pkg;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_POWER_KEY_FIRST = 8'h04;
  localparam logic [7:0] OFS_POWER_MODE_CONFIG = 8'h08;
  localparam logic [7:0] OFS_POWER_KEY_SECOND = 8'h0c;
  localparam logic [7:0] OFS_CLOCK_KEY_FIRST = 8'h10;
  localparam logic [7:0] OFS_CLOCK_SOURCE_CONFIG = 8'h14;
  localparam logic [7:0] OFS_CLOCK_KEY_SECOND = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h24;
  localparam logic [7:0] OFS_CLOCK_STATUS = 8'h28;
  localparam logic [7:0] OFS_CLKOUT_CTRL = 8'h2c;

  // ****************************************************************
  // Keys, reset values and field layout
  // ****************************************************************
  localparam logic [7:0] CLOCK_KEY1_VAL = 8'haa;
  localparam logic [7:0] CLOCK_KEY2_VAL = 8'h55;
  localparam logic [7:0] POWER_KEY1_VAL = 8'h01;
  localparam logic [7:0] POWER_KEY2_VAL = 8'hf4;
  localparam logic [7:0] CLK_CFG_RST = 8'h21;
  localparam logic [7:0] PWR_CFG_RST = 8'h03;
  localparam logic [7:0] CLK_CFG_MASK = 8'h23;
  localparam logic [7:0] PWR_CFG_MASK = 8'h77;
  localparam int unsigned SLOW_OSC_SELECT_BIT = 5;
  localparam int unsigned CLOCK_SOURCE_SELECT_LSB = 0;
  localparam int unsigned PC_LSB = 4;
  localparam int unsigned CD_LSB = 0;
  localparam logic [10:0] PLL_MULT = 11'h4fb;

  // ****************************************************************
  // Interrupt status and reset cause bits
  // ****************************************************************
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_LOCK_LOST = 0;
  localparam int unsigned IRQ_WAKE = 1;
  localparam int unsigned IRQ_KEY_FAULT = 2;
  localparam int unsigned CAUSE_W = 3;
  localparam logic [1:0] CAUSE_WINDOW = 2'h3;

  // ****************************************************************
  // Wake-up timing
  // ****************************************************************
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned WAKE_FAST_NS = 24;
  localparam int unsigned WAKE_SLOW_NS = 3060;
  localparam int unsigned SLEEP_WAKE_NS = 1580000;
  localparam int unsigned STOP_WAKE_NS = 1700000;
  localparam int unsigned WAKE_CNT_W = 17;
  localparam logic [16:0] WAKE_FAST_CYC =
    17'((WAKE_FAST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [16:0] WAKE_SLOW_CYC =
    17'((WAKE_SLOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam int unsigned SLEEP_WAKE_CYC =
    (SLEEP_WAKE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned STOP_WAKE_CYC =
    (STOP_WAKE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PS_ACTIVE = 3'b000,
    PS_PAUSE = 3'b001,
    PS_NAP = 3'b010,
    PS_SLEEP = 3'b011,
    PS_STOP = 3'b100
  } pllcp_pstate_e;

  typedef enum logic [1:0] {
    SRC_PLL = 2'b01,
    SRC_EXT = 2'b11
  } pllcp_src_e;

  typedef enum logic [2:0] {
    KS_IDLE = 3'b000,
    KS_CLK_ARMED = 3'b001,
    KS_CLK_HELD = 3'b010,
    KS_PWR_ARMED = 3'b011,
    KS_PWR_HELD = 3'b100
  } pllcp_key_e;

  typedef struct packed {
    logic core;
    logic periph;
    logic pll;
    logic xtal;
    logic ext_irq;
  } pllcp_domains_s;

endpackage : pllcp_pkg

// [core/pllcp_core_div.sv]
`timescale 1ns/100ps
module pllcp_core_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_src_tick,
  input wire logic i_run,
  input wire logic [2:0] i_div,
  output logic o_core_tick,
  output logic o_clk_out
);
  import pllcp_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
    logic out;
  } pllcp_div_s;

  pllcp_div_s s_q;
  pllcp_div_s s_d;
  logic [6:0] last;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // RULE2: power-of-two division
    last = 7'((8'h01 << i_div) - 8'h01);
    if (!i_run) begin
      s_d.cnt = '0;
    end else if (i_src_tick) begin
      if (s_q.cnt >= last) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
        s_d.out = ~s_q.out;
      end else begin
        s_d.cnt = s_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_core_tick = s_q.tick;
  assign o_clk_out = s_q.out;

endmodule : pllcp_core_div

// [core/pllcp_top.sv]
`timescale 1ns/100ps
module pllcp_top #(
  parameter int unsigned P_SLEEP_WAKE_CYC = pllcp_pkg::SLEEP_WAKE_CYC,
  parameter int unsigned P_STOP_WAKE_CYC = pllcp_pkg::STOP_WAKE_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic [pllcp_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_PLL_LOCK,
  input wire logic I_ECLK,
  input wire logic I_ECLK_MODE2,
  input wire logic [3:0] I_EXT_IRQ,
  input wire logic I_TIMER2_IRQ,
  input wire logic I_PERIPH_IRQ,
  input wire logic [pllcp_pkg::CAUSE_W-1:0] I_RST_SRC,
  output pllcp_pkg::pllcp_domains_s O_DOMAINS,
  output logic O_CORE_TICK,
  output logic O_CORE_CLK_OUT,
  output logic O_CORE_CLK_OUT_OE,
  output logic O_OSC_INTERNAL,
  output logic [10:0] O_PLL_MULT,
  output logic O_IRQ
);
  import pllcp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    pllcp_key_e key;
    logic [7:0] pend;
    logic [7:0] clk_cfg;
    logic [7:0] pwr_cfg;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [CAUSE_W-1:0] cause;
    logic [1:0] cause_cnt;
    logic clkout_en;
    logic waking;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic lock_prev;
    logic eclk_prev;
    logic [9:0] sync1;
    logic [9:0] sync2;
    pllcp_domains_s dom;
  } pllcp_state_s;

  pllcp_state_s s_q;
  pllcp_state_s s_d;

  // ****************************************************************
  // Working signals
  // ****************************************************************
  logic wr_go;
  logic [7:0] wb;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic lock_s;
  logic eclk_s;
  logic [3:0] ext_irq_s;
  logic [CAUSE_W-1:0] rst_src_s;
  pllcp_pstate_e pstate;
  logic [2:0] cd;
  logic src_is_ext;
  logic src_ok;
  logic src_tick;
  logic core_run;
  logic wake_req;
  logic [WAKE_CNT_W-1:0] fast_cyc;
  logic [WAKE_CNT_W-1:0] wake_load;
  logic core_tick;
  logic clk_out;

  // ****************************************************************
  // Decoded views of the state
  // ****************************************************************
  // Only the second synchroniser stage is read, to keep metastability out.
  assign lock_s = s_q.sync2[0];
  assign eclk_s = s_q.sync2[1];
  assign ext_irq_s = s_q.sync2[5:2];
  assign rst_src_s = s_q.sync2[8:6];

  // ****************************************************************
  // Register fields
  // ****************************************************************
  // RULE5: mode and divider from registers
  assign pstate = pllcp_pstate_e'(s_q.pwr_cfg[PC_LSB +: 3]);
  assign cd = s_q.pwr_cfg[CD_LSB +: 3];
  assign src_is_ext = s_q.clk_cfg[CLOCK_SOURCE_SELECT_LSB +: 2] == SRC_EXT;
  // A write lands only in its second cycle, once the wait is lifted.
  assign wr_go = I_AVS_WRITE & s_q.ack;
  assign wb = I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : 8'h00;

  // ****************************************************************
  // Core clock source
  // ****************************************************************
  // RULE13: external clock only in pin mode two
  // RULE11: no core clock without lock
  assign src_ok = src_is_ext ? I_ECLK_MODE2 : lock_s;
  // The PLL output is modelled by the block clock itself.
  assign src_tick = src_is_ext ? (eclk_s & ~s_q.eclk_prev) : 1'b1;
  assign core_run = s_q.dom.core & src_ok;

  // ****************************************************************
  // Wake-up length and sources
  // ****************************************************************
  // Sleep and stop delays are parameters, so a bench can shorten them.
  // RULE15: pause and nap wake scales with divider
  assign fast_cyc = WAKE_FAST_CYC << cd;

  always_comb begin
    wake_load = WAKE_FAST_CYC;
    case (pstate)
      PS_PAUSE, PS_NAP: begin
        wake_load = (fast_cyc > WAKE_SLOW_CYC) ? WAKE_SLOW_CYC : fast_cyc;
      end
      PS_SLEEP: begin
        wake_load = WAKE_CNT_W'(P_SLEEP_WAKE_CYC);
      end
      PS_STOP: begin
        wake_load = WAKE_CNT_W'(P_STOP_WAKE_CYC);
      end
      default: begin
        wake_load = WAKE_FAST_CYC;
      end
    endcase
  end

  // RULE17: wake sources by power state
  always_comb begin
    case (pstate)
      PS_PAUSE, PS_NAP: wake_req = |ext_irq_s | I_TIMER2_IRQ | I_PERIPH_IRQ;
      PS_SLEEP: wake_req = |ext_irq_s | I_TIMER2_IRQ;
      PS_STOP: wake_req = |ext_irq_s;
      PS_ACTIVE: wake_req = 1'b0;
      // Reserved codes gate like stop, so they also wake like stop.
      default: wake_req = |ext_irq_s;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    irq_set = '0;
    irq_clr = '0;
    // Lock, clock, external interrupt and reset source pins are sampled in one word; the top bit is spare.
    s_d.sync1 = {1'b0, I_RST_SRC, I_EXT_IRQ, I_ECLK, I_PLL_LOCK};
    s_d.sync2 = s_q.sync1;
    s_d.lock_prev = lock_s;
    s_d.eclk_prev = eclk_s;

    // Bus handshake: one wait cycle for every access.
    s_d.ack = (I_AVS_READ | I_AVS_WRITE) & ~s_q.ack;
    if (I_AVS_READ && !s_q.ack) begin
      s_d.rdata = '0;
      case (I_AVS_ADDRESS)
        OFS_POWER_MODE_CONFIG: s_d.rdata[7:0] = s_q.pwr_cfg;
        OFS_CLOCK_SOURCE_CONFIG: s_d.rdata[7:0] = s_q.clk_cfg;
        OFS_IRQ_STATUS: s_d.rdata[IRQ_W-1:0] = s_q.irq_st;
        OFS_IRQ_MASK: s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
        OFS_RESET_CAUSE: s_d.rdata[CAUSE_W-1:0] = s_q.cause;
        OFS_CLOCK_STATUS: s_d.rdata[2:0] = {s_q.waking, core_run, lock_s};
        OFS_CLKOUT_CTRL: s_d.rdata[0] = s_q.clkout_en;
        default: s_d.rdata = '0;
      endcase
    end

    if (wr_go) begin
      // Any other write ends a key sequence, so a stray store cannot commit.
      s_d.key = KS_IDLE;
      case (I_AVS_ADDRESS)
        // RULE16: clock key sequence
        OFS_CLOCK_KEY_FIRST: begin
          if (wb == CLOCK_KEY1_VAL) begin
            s_d.key = KS_CLK_ARMED;
          end
        end
        OFS_CLOCK_SOURCE_CONFIG: begin
          if (s_q.key == KS_CLK_ARMED) begin
            s_d.key = KS_CLK_HELD;
            s_d.pend = wb & CLK_CFG_MASK;
          end else begin
            // RULE19: unframed write ignored
            irq_set[IRQ_KEY_FAULT] = 1'b1;
          end
        end
        OFS_CLOCK_KEY_SECOND: begin
          if (s_q.key == KS_CLK_HELD && wb == CLOCK_KEY2_VAL) begin
            // RULE6: source select commit
            // RULE10: source switched before nap wake
            s_d.clk_cfg = s_q.pend;
          end else if (s_q.key == KS_CLK_HELD) begin
            irq_set[IRQ_KEY_FAULT] = 1'b1;
          end
        end
        // RULE16: power key sequence
        OFS_POWER_KEY_FIRST: begin
          if (wb == POWER_KEY1_VAL) begin
            s_d.key = KS_PWR_ARMED;
          end
        end
        OFS_POWER_MODE_CONFIG: begin
          if (s_q.key == KS_PWR_ARMED) begin
            s_d.key = KS_PWR_HELD;
            s_d.pend = wb & PWR_CFG_MASK;
          end else begin
            // RULE19: unframed write ignored
            irq_set[IRQ_KEY_FAULT] = 1'b1;
          end
        end
        OFS_POWER_KEY_SECOND: begin
          if (s_q.key == KS_PWR_HELD && wb == POWER_KEY2_VAL) begin
            // RULE7: power mode commit
            s_d.pwr_cfg = s_q.pend;
            s_d.waking = 1'b0;
          end else if (s_q.key == KS_PWR_HELD) begin
            irq_set[IRQ_KEY_FAULT] = 1'b1;
          end
        end
        OFS_IRQ_STATUS: irq_clr = wb[IRQ_W-1:0];
        OFS_IRQ_MASK: s_d.irq_mask = wb[IRQ_W-1:0];
        OFS_RESET_CAUSE: s_d.cause = s_q.cause & ~wb[CAUSE_W-1:0];
        OFS_CLKOUT_CTRL: s_d.clkout_en = wb[0];
        default: begin
        end
      endcase
    end

    // The cause bits gather for a few cycles, since the source lags reset.
    // RULE12: reset cause for software check
    if (s_q.cause_cnt != CAUSE_WINDOW) begin
      s_d.cause_cnt = s_q.cause_cnt + 2'h1;
      s_d.cause = s_q.cause | rst_src_s;
    end

    // In external mode the lock does not matter, so its loss is not flagged.
    // RULE11: lock loss interrupt
    if (!src_is_ext && s_q.dom.pll && s_q.lock_prev && !lock_s) begin
      irq_set[IRQ_LOCK_LOST] = 1'b1;
    end

    // Wake-up: domains return first, the core after the delay.
    if (s_q.waking) begin
      if (s_q.wake_cnt <= WAKE_CNT_W'(1)) begin
        s_d.waking = 1'b0;
        irq_set[IRQ_WAKE] = 1'b1;
      end else begin
        s_d.wake_cnt = s_q.wake_cnt - WAKE_CNT_W'(1);
      end
    end else if (wake_req) begin
      s_d.waking = 1'b1;
      s_d.wake_cnt = wake_load;
      s_d.pwr_cfg[PC_LSB +: 3] = PS_ACTIVE;
    end

    // Domains follow the next mode, so gating acts on a commit at once.
    // RULE14: domain gating per mode
    s_d.dom = '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal: 1'b1,
      ext_irq: 1'b1};
    case (pllcp_pstate_e'(s_d.pwr_cfg[PC_LSB +: 3]))
      PS_ACTIVE: s_d.dom.core = ~s_d.waking;
      PS_PAUSE: s_d.dom.core = 1'b0;
      PS_NAP: begin
        s_d.dom.core = 1'b0;
        s_d.dom.periph = 1'b0;
      end
      PS_SLEEP: begin
        s_d.dom.core = 1'b0;
        s_d.dom.periph = 1'b0;
        s_d.dom.pll = 1'b0;
      end
      default: begin
        s_d.dom.core = 1'b0;
        s_d.dom.periph = 1'b0;
        s_d.dom.pll = 1'b0;
        s_d.dom.xtal = 1'b0;
      end
    endcase

    // A new event wins over a clear in the same cycle.
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      // Clearing the whole state first keeps every spare bit defined.
      s_q <= '0;
      // RULE18: internal oscillator by default
      s_q.clk_cfg <= CLK_CFG_RST;
      // RULE3: divider three after reset
      s_q.pwr_cfg <= PWR_CFG_RST;
      s_q.key <= KS_IDLE;
      s_q.dom <= '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal: 1'b1,
        ext_irq: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Core clock divider
  // ****************************************************************
  pllcp_core_div u_div (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_src_tick(src_tick),
    .i_run(core_run),
    .i_div(cd),
    .o_core_tick(core_tick),
    .o_clk_out(clk_out)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_AVS_READDATA = s_q.rdata;
  // Waitrequest is combinational, so every request waits exactly once.
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~s_q.ack;
  assign O_DOMAINS = s_q.dom;
  assign O_CORE_TICK = core_tick;
  // RULE4: unbuffered core clock out
  assign O_CORE_CLK_OUT = clk_out & s_q.clkout_en;
  assign O_CORE_CLK_OUT_OE = s_q.clkout_en;
  // RULE18: slow oscillator choice to analog
  assign O_OSC_INTERNAL = s_q.clk_cfg[SLOW_OSC_SELECT_BIT];
  // RULE1: PLL feedback multiple
  assign O_PLL_MULT = PLL_MULT;
  // The interrupt is a level, so it stays high until software clears it.
  assign O_IRQ = |(s_q.irq_st & s_q.irq_mask);

endmodule : pllcp_top

// [sim/pllcp_sva.sv]
`timescale 1ns/100ps
module pllcp_chk (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire pllcp_pkg::pllcp_domains_s O_DOMAINS,
  input wire logic O_CORE_TICK,
  input wire logic O_CORE_CLK_OUT,
  input wire logic O_CORE_CLK_OUT_OE,
  input wire logic O_OSC_INTERNAL,
  input wire logic [10:0] O_PLL_MULT,
  input wire logic O_IRQ
);
  import pllcp_pkg::*;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  sequence req_s;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence ans_s;
    !O_AVS_WAITREQUEST;
  endsequence
  one_wait_a: assert property (req_s |=> ans_s)
    else $error("register access not answered after one wait");
  idle_wait_a: assert property (
    !(I_AVS_READ || I_AVS_WRITE) |-> !O_AVS_WAITREQUEST)
    else $error("wait raised without a request");
  upper_zero_a: assert property (O_AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  pll_mult_a: assert property (O_PLL_MULT == PLL_MULT)
    else $error("multiplier not 1275");
  ext_irq_on_a: assert property (O_DOMAINS.ext_irq)
    else $error("external interrupt domain gated");
  gate_order_a: assert property (!O_DOMAINS.xtal |->
    !O_DOMAINS.pll && !O_DOMAINS.periph && !O_DOMAINS.core)
    else $error("domain on below a gated crystal domain");
  nap_core_a: assert property (
    !O_DOMAINS.periph |-> !O_DOMAINS.core)
    else $error("core on while peripherals gated");
  core_gate_a: assert property (
    !O_DOMAINS.core [*2] |-> !O_CORE_TICK)
    else $error("core tick while core domain off");
  reset_vals_a: assert property ($fell(I_SYS_RST) |->
    O_OSC_INTERNAL && !O_CORE_CLK_OUT_OE && !O_IRQ &&
    O_DOMAINS == 5'h1f)
    else $error("wrong output values after reset");
  clk_out_a: assert property (O_CORE_CLK_OUT_OE &&
    $past(O_CORE_CLK_OUT_OE) && $changed(O_CORE_CLK_OUT) |->
    O_CORE_TICK || $past(O_CORE_TICK))
    else $error("clock pin toggled without a core tick");
endmodule : pllcp_chk

bind pllcp_top pllcp_chk u_chk (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_DOMAINS(O_DOMAINS), .O_CORE_TICK(O_CORE_TICK),
  .O_CORE_CLK_OUT(O_CORE_CLK_OUT), .O_CORE_CLK_OUT_OE(O_CORE_CLK_OUT_OE),
  .O_OSC_INTERNAL(O_OSC_INTERNAL), .O_PLL_MULT(O_PLL_MULT), .O_IRQ(O_IRQ));

// [sim/pllcp_xtal_model.sv]
`timescale 1ns/100ps
module pllcp_xtal_model (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_lock_ok,
  output logic o_eclk,
  output logic o_lock
);
  // ****************************************************************
  // External source
  // ****************************************************************
  logic [1:0] cnt_q;
  // The source runs only while i_run is high, well below the limit.
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      cnt_q <= 2'h0;
      o_eclk <= 1'b0;
    end else if (cnt_q == 2'h2) begin
      cnt_q <= 2'h0;
      o_eclk <= !o_eclk;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Lock follows the request a cycle late, like a real loop.
  always_ff @(posedge i_clk) begin
    o_lock <= i_lock_ok;
  end
endmodule : pllcp_xtal_model

// [sim/tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  miscompares++; $display("wrong value %s expected %h seen %h", n, e, s); \
  end end
module tb_top;
  import pllcp_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int SLP = 20;
  localparam int STP = 30;
  logic mclk, rst, rd, wr, lock, eclk, mode2, t2, run, lock_ok;
  logic wreq, tick, cko, oe, osc, irq, pirq;
  logic [7:0] addr;
  logic [31:0] wdat, rdata, rdat;
  logic [3:0] eirq;
  logic [2:0] rsrc;
  logic [4:0] exp_dom [1:4];
  pllcp_domains_s dom;
  int miscompares, cmp_count, p, n, i;
  integer seed = 32'h98f3c042;
  logic [7:0] v;

  pllcp_top #(.P_SLEEP_WAKE_CYC(SLP), .P_STOP_WAKE_CYC(STP)) dut (
    .I_MCLK(mclk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat),
    .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq), .I_PLL_LOCK(lock), .I_ECLK(eclk),
    .I_ECLK_MODE2(mode2), .I_EXT_IRQ(eirq), .I_TIMER2_IRQ(t2),
    .I_PERIPH_IRQ(pirq), .I_RST_SRC(rsrc), .O_DOMAINS(dom),
    .O_CORE_TICK(tick), .O_CORE_CLK_OUT(cko), .O_CORE_CLK_OUT_OE(oe),
    .O_OSC_INTERNAL(osc), .O_PLL_MULT(), .O_IRQ(irq));
  pllcp_xtal_model u_xtal (.i_clk(mclk), .i_run(run),
    .i_lock_ok(lock_ok), .o_eclk(eclk), .o_lock(lock));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    addr <= a;
    wdat <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (wreq !== 1'b0) miscompares++;
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge mclk);
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 8'h0);
    `CHK(nm, e, rdat)
  endtask : rchk

  // Keys are written whole; any stray write in between spoils them.
  task automatic cfg(input logic c, input logic [7:0] val);
    bus(1'b1, c ? OFS_CLOCK_KEY_FIRST : OFS_POWER_KEY_FIRST,
        c ? CLOCK_KEY1_VAL : POWER_KEY1_VAL);
    bus(1'b1, c ? OFS_CLOCK_SOURCE_CONFIG : OFS_POWER_MODE_CONFIG, val);
    bus(1'b1, c ? OFS_CLOCK_KEY_SECOND : OFS_POWER_KEY_SECOND,
        c ? CLOCK_KEY2_VAL : POWER_KEY2_VAL);
  endtask : cfg

  // The first tick after a change may be short, so two are skipped.
  task automatic per(output int q);
    int k;
    k = 0;
    q = 0;
    repeat (2) begin
      do begin
        @(negedge mclk);
        k++;
      end while (tick !== 1'b1 && k < 600);
    end
    do begin
      @(negedge mclk);
      q++;
    end while (tick !== 1'b1 && q < 600);
  endtask : per

  task automatic wake(output int q);
    q = 0;
    do begin
      @(negedge mclk);
      q++;
    end while (dom.core !== 1'b1 && q < 400);
  endtask : wake

  function automatic int wake_cyc(input int m);
    return (m == 3) ? SLP : (m == 4) ? STP :
           (m == 0) ? int'(WAKE_FAST_CYC) : int'(WAKE_SLOW_CYC);
  endfunction : wake_cyc

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    print_verdict;
  end

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h0;
    wdat = 32'h0;
    eirq = 4'h0;
    t2 = 1'b0;
    pirq = 1'b0;
    mode2 = 1'b0;
    run = 1'b0;
    lock_ok = 1'b1;
    rsrc = 3'h4;
    exp_dom = '{5'h0f, 5'h07, 5'h03, 5'h01};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rsrc <= 3'h0;
    rchk("reset_cause", OFS_RESET_CAUSE, 32'h4);
    rchk("clock_cfg", OFS_CLOCK_SOURCE_CONFIG, 32'h21);
    rchk("power_cfg", OFS_POWER_MODE_CONFIG, 32'h3);
    rchk("unmapped", 8'h40, 32'h0);
    per(p);
    `CHK("reset_period", 8, p)
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      bus(1'b1, OFS_POWER_MODE_CONFIG, v);
      rchk("ignored", OFS_POWER_MODE_CONFIG,
           (i == 0) ? 32'h3 : 32'(i - 1));
      cfg(1'b0, 8'(i));
      per(p);
      `CHK("period", 1 << i, p)
    end
    rchk("key_fault", OFS_IRQ_STATUS, 32'h4);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, OFS_IRQ_MASK, 8'h4);
    `CHK("irq_raised", 1'b1, irq)
    bus(1'b1, OFS_IRQ_STATUS, 8'h4);
    `CHK("irq_cleared", 1'b0, irq)
    cfg(1'b1, 8'h01);
    `CHK("osc_internal", 1'b0, osc)
    for (i = 1; i < 5; i++) begin
      cfg(1'b0, {1'b0, 3'(i), 4'h7});
      `CHK("domains", exp_dom[i], dom)
      @(posedge mclk);
      if (i == 2) t2 <= 1'b1;
      else if (i == 1) pirq <= 1'b1;
      else eirq[i - 1] <= 1'b1;
      wake(n);
      @(posedge mclk);
      t2 <= 1'b0;
      pirq <= 1'b0;
      eirq <= 4'h0;
      `CHK("wake_early", 1'b1, n >= wake_cyc(i))
      `CHK("wake_late", 1'b1, n <= wake_cyc(i) + 6)
      rchk("awake", OFS_POWER_MODE_CONFIG, 32'h7);
    end
    cfg(1'b0, 8'h10);
    `CHK("pause_dom", exp_dom[1], dom)
    @(posedge mclk);
    pirq <= 1'b1;
    wake(n);
    @(posedge mclk);
    pirq <= 1'b0;
    `CHK("fast_early", 1'b1, n >= wake_cyc(0))
    `CHK("fast_late", 1'b1, n <= wake_cyc(0) + 6)
    rchk("source_kept", OFS_CLOCK_SOURCE_CONFIG, 32'h1);
    rchk("wake_flag", OFS_IRQ_STATUS, 32'h2);
    bus(1'b1, OFS_IRQ_STATUS, 8'h2);
    cfg(1'b0, 8'h0);
    bus(1'b1, OFS_CLKOUT_CTRL, 8'h1);
    `CHK("clk_out_oe", 1'b1, oe)
    @(posedge mclk);
    lock_ok <= 1'b0;
    repeat (6) @(posedge mclk);
    n = 0;
    repeat (20) begin
      @(negedge mclk);
      if (tick !== 1'b0) n++;
    end
    `CHK("halted_ticks", 0, n)
    @(posedge mclk);
    lock_ok <= 1'b1;
    rchk("lock_flag", OFS_IRQ_STATUS, 32'h1);
    per(p);
    `CHK("relock_period", 1, p)
    v[0] = cko;
    @(negedge mclk);
    `CHK("clk_out_toggle", !v[0], cko)
    @(posedge mclk);
    mode2 <= 1'b1;
    run <= 1'b1;
    bus(1'b1, OFS_CLOCK_KEY_FIRST, CLOCK_KEY1_VAL);
    bus(1'b1, 8'h40, 8'h0);
    bus(1'b1, OFS_CLOCK_SOURCE_CONFIG, 8'h03);
    bus(1'b1, OFS_CLOCK_KEY_SECOND, CLOCK_KEY2_VAL);
    rchk("broken_key", OFS_CLOCK_SOURCE_CONFIG, 32'h1);
    cfg(1'b1, 8'h03);
    rchk("ext_select", OFS_CLOCK_SOURCE_CONFIG, 32'h3);
    per(p);
    `CHK("ext_period", 6, p)
    print_verdict;
  end
endmodule : tb_top
